// *** pkg/adc_demux_pkg.sv ***
// Purpose: Shared constants, types and register map of the converter output stage.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes: Offsets are byte addresses.
package adc_demux_pkg;
	localparam int DATA_W = 8;
	localparam int IRQ_W = 3;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_LAST_WORD = 8'h14;

	// Field positions
	localparam int CTRL_SPLIT_BIT = 0;
	localparam int CTRL_RATE_BIT = 1;
	localparam int IRQ_WORD_BIT = 0;
	localparam int IRQ_OVR_BIT = 1;
	localparam int IRQ_RST_BIT = 2;

	// Values after reset
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 3'h0;
	localparam logic [1:0] PHASE_RESET = 2'h0;

	// Codes
	localparam logic [DATA_W-1:0] FULL_SCALE_CODE = 8'hff;
	localparam logic [DATA_W-1:0] LINES_HIGH = 8'hff;

	typedef struct packed {
		logic ovr;
		logic [DATA_W-1:0] code;
	} sample_s;

	typedef enum logic [2:0] {
		MODE_PASS = 3'b001,
		MODE_SPLIT = 3'b010,
		MODE_DECIM = 3'b100
	} mode_e;
endpackage : adc_demux_pkg

// *** logic/adc_output_demux_overrange.sv ***
// Purpose: Output stage of an 8-bit converter: pass-through, 1:2 split or decimate-by-two split.
// Assumes: Sample clock, sample data and all pins are asynchronous to hclk and much slower.
// Notes: Sample data must be stable around the sample-clock rising edge.
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// - Samples leave on the ports as unsigned offset-binary codes, zeros most negative.
// - Split enable high activates the demultiplexer; low gives pass-through, rate ignored.
// - With demultiplexer active, rate select low is split, high is decimate.
// - Pass-through puts each sample on port one, port two one sample later.
// - Both second-port power inputs low force all second-port lines high.
// - Split mode sends older sample on port two, newer on port one.
// - Decimate mode drops every other sample and splits the rest over both ports.
// - In split and decimate modes overrange flags if either sample overranged.
// - In pass-through overrange follows only the first-port sample.
// - Port data and overrange change on the strobe clock rising edge.
// - Each port has eight true and complementary lanes, LSB to MSB.
// - Zero input gives a mid-scale code toggling between 7f and 80.
// - Overrange is one only at full-scale code ff, otherwise zero.
// - A new sample is taken on each sampling-clock rising edge.
// - While sync reset in is asserted, demultiplexer phase is held reset.
module adc_output_demux_overrange #(
	parameter int DATA_W = 8
) (
	input wire logic hclk, // Bus and core clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	output logic [31:0] hrdata, // AHB read data
	input wire logic sample_clk, // Sampling clock pin
	input wire adc_demux_pkg::sample_s sample_in, // Converted code and overrange
	input wire logic sync_reset_in, // Demux reset pin, active high
	input wire logic second_port_power_a, // Second-port power input a
	input wire logic second_port_power_b, // Second-port power input b
	output logic [7:0] first_port_bits_p, // First port true lines
	output logic [7:0] first_port_bits_n, // First port complementary lines
	output logic [7:0] second_port_bits_p, // Second port true lines
	output logic [7:0] second_port_bits_n, // Second port complementary lines
	output logic overrange_p, // Overrange true line
	output logic overrange_n, // Overrange complementary line
	output logic output_strobe_clock_p, // Data-ready clock true line
	output logic output_strobe_clock_n, // Data-ready clock complementary line
	output logic sync_reset_out, // Reset passed on to later stages
	output logic irq // Level interrupt
);
	import adc_demux_pkg::*;

	// Ports and the sample struct are fixed at eight bits
	if (DATA_W != 8) begin : g_width_check
		$error("DATA_W must be 8");
	end

	// Pin synchronisers; stage one is read only by stage two
	logic clk_s1, clk_s2, clk_s3;
	sample_s smp_s1, smp_s2;
	logic rst_s1, rst_s2, rst_s3;
	logic [1:0] pwr_s1, pwr_s2v;
	logic pwr_s2;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			smp_s1 <= '0;
			smp_s2 <= '0;
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
			rst_s3 <= 1'b0;
			pwr_s1 <= 2'b11;
			pwr_s2v <= 2'b11;
		end else begin
			clk_s1 <= sample_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			smp_s1 <= sample_in;
			smp_s2 <= smp_s1;
			rst_s1 <= sync_reset_in;
			rst_s2 <= rst_s1;
			rst_s3 <= rst_s2;
			pwr_s1 <= {second_port_power_a, second_port_power_b};
			pwr_s2v <= pwr_s1;
		end
	end

	logic samp_rise, samp_fall;
	assign samp_rise = clk_s2 & ~clk_s3;
	assign samp_fall = ~clk_s2 & clk_s3;
	// Each power pin synced on its own; an or before the flops could glitch
	assign pwr_s2 = |pwr_s2v;

	// Registers
	logic [1:0] ctrl_reg;
	logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg, irq_set;
	mode_e mode;

	// Mode follows CTRL at once; software issues a sync reset after a change
	always_comb begin
		if (!ctrl_reg[CTRL_SPLIT_BIT]) begin
			mode = MODE_PASS;
		end else if (ctrl_reg[CTRL_RATE_BIT]) begin
			mode = MODE_DECIM;
		end else begin
			mode = MODE_SPLIT;
		end
	end

	// Core datapath
	sample_s cur;
	sample_s hold_reg;
	sample_s first_reg, second_reg;
	logic ovr_reg, strobe_reg;
	logic [1:0] phase_reg;
	logic word_evt;
	logic cur_ovr;

	// Flag only a genuine full-scale code
	assign cur_ovr = smp_s2.ovr & (smp_s2.code == FULL_SCALE_CODE);
	assign cur = '{ovr: cur_ovr, code: smp_s2.code};

	always_comb begin
		word_evt = 1'b0;
		case (mode)
			MODE_PASS: word_evt = samp_rise;
			MODE_SPLIT: word_evt = samp_rise & phase_reg[0];
			MODE_DECIM: word_evt = samp_rise & (phase_reg == 2'h2);
			default: word_evt = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= PHASE_RESET;
		end else if (rst_s2) begin
			phase_reg <= PHASE_RESET;
		end else if (samp_rise) begin
			case (mode)
				MODE_PASS: phase_reg <= PHASE_RESET;
				MODE_SPLIT: phase_reg <= {1'b0, ~phase_reg[0]};
				MODE_DECIM: phase_reg <= phase_reg + 2'h1;
				default: phase_reg <= PHASE_RESET;
			endcase
		end
	end

	// Older sample of a pair waits here; decimate skips odd phases
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_reg <= '0;
		end else if (samp_rise && phase_reg == 2'h0 && mode != MODE_PASS) begin
			hold_reg <= cur;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_reg <= '0;
			second_reg <= '0;
			ovr_reg <= 1'b0;
		end else if (word_evt) begin
			if (mode == MODE_PASS) begin
				first_reg <= cur;
				second_reg <= first_reg;
				ovr_reg <= cur.ovr;
			end else begin
				first_reg <= cur;
				second_reg <= hold_reg;
				ovr_reg <= cur.ovr | hold_reg.ovr;
			end
		end
	end

	// Strobe rises with the data; falls half a word later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe_reg <= 1'b0;
		end else if (word_evt) begin
			strobe_reg <= 1'b1;
		end else if (mode == MODE_PASS && samp_fall) begin
			strobe_reg <= 1'b0;
		end else if (mode != MODE_PASS && samp_rise && phase_reg == 2'h0) begin
			strobe_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_reset_out <= 1'b0;
		end else if (samp_rise) begin
			sync_reset_out <= rst_s2;
		end
	end

	// Differential lanes; unpowered second port pulls both lines high
	assign first_port_bits_p = first_reg.code;
	assign first_port_bits_n = ~first_reg.code;
	assign second_port_bits_p = pwr_s2 ? second_reg.code : LINES_HIGH;
	assign second_port_bits_n = pwr_s2 ? ~second_reg.code : LINES_HIGH;
	assign overrange_p = ovr_reg;
	assign overrange_n = ~ovr_reg;
	assign output_strobe_clock_p = strobe_reg;
	assign output_strobe_clock_n = ~strobe_reg;

	// AHB-Lite slave: writes zero wait, reads one wait state
	logic ap_take;
	logic dp_valid, dp_write, dp_hit, rd_wait;
	logic [7:0] dp_addr;
	logic wr_en;
	logic [31:0] rd_mux;

	assign ap_take = hsel & htrans[1] & hready;
	assign hreadyout = ~rd_wait;
	assign hresp = 1'b0;
	assign wr_en = dp_valid & dp_write & dp_hit & hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_hit <= 1'b0;
			dp_addr <= 8'h00;
			rd_wait <= 1'b0;
		end else begin
			if (hready) begin
				dp_valid <= ap_take;
				dp_write <= hwrite;
				dp_hit <= (haddr[31:8] == 24'h000000);
				dp_addr <= haddr[7:0];
			end
			rd_wait <= ap_take & ~hwrite;
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (dp_hit) begin
			case (dp_addr)
				ADDR_CTRL: rd_mux = {30'h0, ctrl_reg};
				ADDR_STATUS: rd_mux = {24'h0, pwr_s2, rst_s2, phase_reg, 1'b0, mode};
				ADDR_IRQ_STATUS: rd_mux = {29'h0, irq_status_reg};
				ADDR_IRQ_ENABLE: rd_mux = {29'h0, irq_enable_reg};
				ADDR_LAST_WORD: rd_mux = {15'h0, ovr_reg, second_reg.code, first_reg.code};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_wait) begin
			hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= CTRL_RESET;
			irq_enable_reg <= IRQ_ENABLE_RESET;
		end else if (wr_en) begin
			if (dp_addr == ADDR_CTRL) begin
				ctrl_reg <= hwdata[1:0];
			end
			if (dp_addr == ADDR_IRQ_ENABLE) begin
				irq_enable_reg <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// Interrupts; a new event wins over a clear in the same cycle
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_WORD_BIT] = word_evt;
		irq_set[IRQ_OVR_BIT] = word_evt & (mode == MODE_PASS ? cur.ovr : cur.ovr | hold_reg.ovr);
		irq_set[IRQ_RST_BIT] = rst_s2 & ~rst_s3;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_reg <= '0;
		end else begin
			if (wr_en && dp_addr == ADDR_IRQ_CLEAR) begin
				irq_status_reg <= (irq_status_reg & ~hwdata[IRQ_W-1:0]) | irq_set;
			end else begin
				irq_status_reg <= irq_status_reg | irq_set;
			end
		end
	end

	assign irq = |(irq_status_reg & irq_enable_reg);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_pass_first_port: assert property (mode == MODE_PASS && samp_rise |=>
		first_reg.code == $past(smp_s2.code)) else $error("pass first port wrong");
	a_pass_second_delay: assert property (mode == MODE_PASS && samp_rise |=>
		second_reg == $past(first_reg)) else $error("second port not one sample late");
	a_power_down_high: assert property (!pwr_s2 |->
		second_port_bits_p == 8'hff && second_port_bits_n == 8'hff)
		else $error("unpowered second port not high");
	a_split_pair_order: assert property (mode == MODE_SPLIT && samp_rise && phase_reg == 2'h1 |=>
		first_reg == $past(cur) && second_reg == $past(hold_reg)) else $error("split order wrong");
	a_decim_drop_odd: assert property (mode == MODE_DECIM && samp_rise && phase_reg[0] |=>
		$stable(first_reg) && $stable(strobe_reg)) else $error("decimate took dropped sample");
	a_or_either_port: assert property (mode != MODE_PASS && word_evt |=>
		ovr_reg == $past(cur.ovr | hold_reg.ovr)) else $error("overrange not or of pair");
	a_or_primary_only: assert property (mode == MODE_PASS && word_evt |=>
		ovr_reg == $past(cur.ovr)) else $error("pass overrange wrong");
	a_strobe_with_data: assert property ($changed(first_reg) |-> $rose(strobe_reg))
		else $error("data changed without strobe rise");
	a_or_full_scale: assert property (mode == MODE_PASS && word_evt |=>
		!ovr_reg || first_reg.code == 8'hff) else $error("overrange below full scale");
	a_demux_reset_hold: assert property (rst_s2 |=> phase_reg == 2'h0)
		else $error("phase not held in reset");
	a_split_strobe_rate: assert property (mode == MODE_SPLIT && samp_rise && phase_reg == 2'h0
		&& !rst_s2 |=> !strobe_reg) else $error("split strobe not half rate");
	a_decim_pair_order: assert property (mode == MODE_DECIM && samp_rise
		&& phase_reg == 2'h2 |=> first_reg == $past(cur) && second_reg == $past(hold_reg))
		else $error("decimate pair wrong");
	a_or_pair_full: assert property (mode != MODE_PASS && word_evt |=>
		!ovr_reg || first_reg.code == 8'hff || second_reg.code == 8'hff)
		else $error("pair overrange below full scale");
	a_power_on_data: assert property (pwr_s2 |->
		second_port_bits_p == second_reg.code && second_port_bits_n == ~second_reg.code)
		else $error("powered second port wrong");
	// Port data moves only on a synced sample edge
	a_sample_edge_only: assert property (!samp_rise |=> $stable(first_reg))
		else $error("port data moved off a sample edge");
	a_pass_strobe_fall: assert property (mode == MODE_PASS && samp_fall |=> !strobe_reg)
		else $error("pass strobe not low after clock fall");
	a_decim_strobe_rate: assert property (mode == MODE_DECIM && samp_rise
		&& phase_reg == 2'h0 |=> !strobe_reg) else $error("decimate strobe not quarter rate");
	a_reset_out_copy: assert property (samp_rise |=> sync_reset_out == $past(rst_s2))
		else $error("reset out not taken on sample edge");
endmodule : adc_output_demux_overrange

// *** tb/capture_model.sv ***
// Purpose: Far-side capture logic for the converter output ports.
// Assumes: Receiver clock is much faster than the data-ready clock.
// Notes: Each word is kept as {ovr p/n, first p/n, second p/n}.
`timescale 1ns/1ns
module capture_model (
	input wire logic hclk, // Receiver clock
	input wire logic strobe, // Data-ready clock true line
	input wire logic [7:0] first_p, // First port true lines
	input wire logic [7:0] first_n, // First port complementary lines
	input wire logic [7:0] second_p, // Second port true lines
	input wire logic [7:0] second_n, // Second port complementary lines
	input wire logic ovr_p, // Overrange true line
	input wire logic ovr_n // Overrange complementary line
);
	logic strobe_q = 1'b0;
	logic [33:0] got_q[$];

	// One cycle after the rise, so data launched with the strobe has settled
	always @(posedge hclk) begin
		strobe_q <= strobe;
		if (strobe && !strobe_q) begin
			got_q.push_back({ovr_p, ovr_n, first_p, first_n, second_p, second_n});
		end
	end
endmodule : capture_model

// *** tb/adc_output_demux_overrange_tb.sv ***
// Purpose: Self-checking bench for the converter output stage.
// Assumes: Capture model on the far side; sample clock period 800 ns.
// Notes: Random samples from a fixed seed, with corner codes mixed in.
`timescale 1ns/1ns
module adc_output_demux_overrange_tb;
	import adc_demux_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic sample_clk = 0, sync_reset_in = 0, pwr = 1, op, on, stb_p, stb_n, rst_out;
	logic [7:0] fp, fn, sp, sn;
	sample_s sample_in = '0;
	sample_s tx_q[$], s[$];
	logic [33:0] exp_q[$];
	logic [8:0] corner [4] = '{9'h1ff, 9'h1fe, 9'h07f, 9'h080};
	int bad_count = 0, check_count = 0, cyc = 0;

	always #50 hclk = ~hclk;
	assign hready = hreadyout;

	adc_output_demux_overrange dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_clk(sample_clk),
		.sample_in(sample_in), .sync_reset_in(sync_reset_in), .second_port_power_a(pwr),
		.second_port_power_b(pwr), .first_port_bits_p(fp), .first_port_bits_n(fn),
		.second_port_bits_p(sp), .second_port_bits_n(sn), .overrange_p(op), .overrange_n(on),
		.output_strobe_clock_p(stb_p), .output_strobe_clock_n(stb_n),
		.sync_reset_out(rst_out), .irq(irq));

	capture_model cap (.hclk(hclk), .strobe(stb_p), .first_p(fp), .first_n(fn),
		.second_p(sp), .second_n(sn), .ovr_p(op), .ovr_n(on));

	// Link clock idles low between bursts; 4 + 4 bus cycles give the 800 ns period
	initial begin
		forever begin
			@(posedge hclk);
			sample_clk <= 1'b0;
			if (tx_q.size() > 0) begin
				sample_in <= tx_q.pop_front();
				repeat (4) @(posedge hclk);
				sample_clk <= 1'b1;
				repeat (3) @(posedge hclk);
			end
		end
	end

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			test_done();
		end
	end

	task test_done;
		if (bad_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
		bus(0, a, 32'h0);
		check(what, {2'b0, rd}, {2'b0, exp});
		check("hresp", {33'h0, hresp}, 34'h0);
	endtask : rdchk

	function automatic logic hit(sample_s x);
		return x.ovr && x.code == FULL_SCALE_CODE;
	endfunction : hit

	function automatic logic [33:0] word(logic o, logic [7:0] f, logic [7:0] a);
		return {o, ~o, f, ~f, a, ~a};
	endfunction : word

	task automatic run(logic [1:0] ctrl, logic pw, int n);
		int step, back, off;
		logic [33:0] m;
		sample_s x;
		logic o;
		logic [31:0] lw;
		step = ctrl[0] ? (ctrl[1] ? 4 : 2) : 1;
		back = (step == 4) ? 2 : 1;
		off = (step == 1) ? 1 : 0;
		bus(1, ADDR_CTRL, {30'h0, ctrl});
		pwr <= pw;
		sync_reset_in <= 1;
		repeat (6) @(posedge hclk);
		sync_reset_in <= 0;
		repeat (6) @(posedge hclk);
		rdchk("status", ADDR_STATUS, {24'h0, pw, 3'h0, 4'(step)});
		cap.got_q.delete();
		s.delete();
		exp_q.delete();
		for (int i = 0; i < n; i++) begin
			x = (i < 4) ? corner[(i + step) % 4] : 9'($urandom);
			if (i >= 4 && $urandom_range(3) == 0) x.code = FULL_SCALE_CODE;
			s.push_back(x);
		end
		for (int i = (step == 1) ? 1 : step / 2; i < n; i += step) begin
			o = hit(s[i]) | (step > 1 && hit(s[i - back]));
			lw = {15'h0, o, s[i - back].code, s[i].code};
			m = word(o, s[i].code, s[i - back].code);
			if (!pw) m[15:0] = 16'hffff;
			exp_q.push_back(m);
		end
		foreach (s[i]) tx_q.push_back(s[i]);
		wait (tx_q.size() == 0);
		for (int k = 0; k < 60 && cap.got_q.size() < exp_q.size() + off; k++) @(posedge hclk);
		repeat (8) @(posedge hclk);
		check("words", 34'(cap.got_q.size()), 34'(exp_q.size() + off));
		foreach (exp_q[k]) begin
			check("word", cap.got_q[k + off], exp_q[k]);
		end
		check("strobe", {32'h0, stb_p, stb_n}, (step == 1) ? 34'h1 : 34'h2);
		rdchk("last word", ADDR_LAST_WORD, lw);
	endtask : run

	initial begin
		int r;
		r = $urandom(32'hb483);
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		rdchk("ctrl", ADDR_CTRL, 32'h0);
		rdchk("irq enable", ADDR_IRQ_ENABLE, 32'h0);
		rdchk("irq clear", ADDR_IRQ_CLEAR, 32'h0);
		rdchk("unmapped", 8'h40, 32'h0);
		bus(1, ADDR_STATUS, 32'hff);
		rdchk("status", ADDR_STATUS, 32'h81);
		bus(1, ADDR_IRQ_ENABLE, 32'h3);
		run(2'b00, 1, 16);
		check("irq", {33'h0, irq}, 34'h1);
		rdchk("irq status", ADDR_IRQ_STATUS, 32'h7);
		bus(1, ADDR_IRQ_CLEAR, 32'h7);
		rdchk("irq status", ADDR_IRQ_STATUS, 32'h0);
		check("irq", {33'h0, irq}, 34'h0);
		bus(1, ADDR_IRQ_ENABLE, 32'h0);
		run(2'b00, 0, 8);
		check("irq", {33'h0, irq}, 34'h0);
		run(2'b10, 1, 8);
		run(2'b01, 1, 16);
		run(2'b11, 1, 16);
		sync_reset_in <= 1;
		repeat (4) @(posedge hclk);
		tx_q.push_back('0);
		wait (tx_q.size() == 0);
		repeat (12) @(posedge hclk);
		check("reset out", {33'h0, rst_out}, 34'h1);
		sync_reset_in <= 0;
		repeat (4) @(posedge hclk);
		tx_q.push_back('0);
		wait (tx_q.size() == 0);
		repeat (12) @(posedge hclk);
		check("reset out", {33'h0, rst_out}, 34'h0);
		test_done();
	end
endmodule : adc_output_demux_overrange_tb
